// ### src/swc_defs.vh
// Constants for the sleep and wake controller: register map, fields, timing.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef SWC_DEFS_VH
`define SWC_DEFS_VH
`define SWC_ADDR_W 8
`define SWC_DATA_W 8
`define SWC_OFS_TIMER0_CFG 8'hB0
`define SWC_OFS_SLEEP_CFG2 8'hB1
`define SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG 8'hB2
`define SWC_OFS_SLEEP_CTRL 8'hB3
`define SWC_OFS_INT_STATUS 8'hB4
`define SWC_OFS_INT_MASK 8'hB5
`define SWC_OFS_STATE 8'hB6
`define SWC_OFS_T0_PERIOD 8'hB7
`define SWC_OFS_ST_PERIOD 8'hB8
`define SWC_T0_ENABLE_BIT 0
`define SWC_T0_ONESHOT_BIT 1
`define SWC_OSC_REFRESH_DIS_BIT 0
`define SWC_CTRL_SLEEP_BIT 0
`define SWC_CTRL_ANALOG_EN_BIT 1
`define SWC_CTRL_ST_EN_BIT 2
`define SWC_INT_GPIO 0
`define SWC_INT_TIMER0 1
`define SWC_INT_SLEEPT 2
`define SWC_INT_ANALOG 3
`define SWC_INT_I2C 4
`define SWC_INT_LOCKUP 5
`define SWC_NUM_INT 6
`define SWC_RESET_BYTE 8'h00
`define SWC_REFRESH_DEFAULT 2'h0
`define SWC_REFRESH_MS 8
`define SWC_CLK_MHZ 125
// 8 ms at 125 MHz, sized to the refresh counter
`define SWC_REFRESH_CYCLES 28'h00F4240
`define SWC_CNT_W 24
`define SWC_DROP_CYCLES 3
`define SWC_LOCK_MS 8
`endif

// ### src/swc_sync.v
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module swc_sync #(
  parameter WIDTH = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;
  // Only the second stage reads the first.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ### src/swc_top.v
// Sleep entry, bandgap refresh, timer 0, wake sources and interrupt status.
// Assumes a 125 MHz clk_sys, pin inputs asynchronous, simple strobe register port.
`include "swc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] In sleep, pulse bandgap power every 8 ms by default.
// [R02] Refresh interval field lengthens period; disable bit stops refresh entirely.
// [R03] Longer than default refresh in sleep may lock up until reset.
// [R04] Firmware keeps refresh interval default and disable clear before sleep.
// [R05] Firmware detaches I2C slave before sleep.
// [R06] External I2C master wakes device before starting a transaction.
// [R07] Timer 0 runs one-shot when bit 1 of config B0h is set.
// [R08] Firmware clears one-shot bit with AND FDh inside service routine.
// [R09] GPIO event coinciding with timer wake in sleep may be lost.
// [R10] Firmware disables timers or samples GPIO in timer routines.
// [R11] Interrupt pending under 2.5 cycles before sleep command is dropped.
// [R12] Firmware disables analog interrupt before sleep.
module swc_top (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire gpio_wake_pin,
  input wire analog_event_pin,
  input wire i2c_wake_pin,
  output reg bandgap_power_en,
  output reg sleeping,
  output reg locked_up,
  output reg irq
);
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_LOCK = 2'h2;
  localparam ST_WAKE = 2'h3;

  wire [2:0] pins_sync;
  reg [2:0] pins_prev;
  reg [7:0] timer0_cfg;
  reg [7:0] sleep_cfg2;
  reg [7:0] oscillator_control_zero_reg;
  reg [7:0] sleep_ctrl;
  reg [7:0] t0_period;
  reg [7:0] st_period;
  reg [`SWC_NUM_INT-1:0] int_status;
  reg [`SWC_NUM_INT-1:0] int_mask;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`SWC_CNT_W+3:0] refresh_cnt;
  reg [7:0] t0_cnt;
  reg [7:0] st_cnt;
  reg [`SWC_DROP_CYCLES*`SWC_NUM_INT-1:0] event_hist;
  reg [`SWC_NUM_INT-1:0] recent_events;
  integer k;
  reg [`SWC_NUM_INT-1:0] events;
  reg [`SWC_NUM_INT-1:0] next_status;
  wire [1:0] bandgap_interval;
  wire [`SWC_CNT_W+3:0] refresh_limit;
  wire refresh_disable;
  wire long_refresh;
  wire wr_ctrl;
  wire sleep_cmd;
  wire t0_fire;
  wire st_fire;
  wire wake_any;
  wire gpio_rise;
  wire analog_rise;
  wire i2c_rise;

  swc_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({i2c_wake_pin, analog_event_pin, gpio_wake_pin}),
    .sync_out(pins_sync)
  );

  assign gpio_rise = pins_sync[0] & ~pins_prev[0];
  assign analog_rise = pins_sync[1] & ~pins_prev[1];
  assign i2c_rise = pins_sync[2] & ~pins_prev[2];

  // Interval field scales the 8 ms base by 1, 2, 4 or 8
  assign bandgap_interval = sleep_cfg2[1:0];
  assign refresh_limit = `SWC_REFRESH_CYCLES << bandgap_interval; // R02
  assign refresh_disable = oscillator_control_zero_reg[`SWC_OSC_REFRESH_DIS_BIT];
  assign long_refresh = refresh_disable | (bandgap_interval != `SWC_REFRESH_DEFAULT);
  assign wr_ctrl = reg_wr && (reg_addr == `SWC_OFS_SLEEP_CTRL);
  assign sleep_cmd = wr_ctrl && reg_wdata[`SWC_CTRL_SLEEP_BIT];
  assign t0_fire = timer0_cfg[`SWC_T0_ENABLE_BIT] && (t0_cnt == t0_period);
  assign st_fire = sleep_ctrl[`SWC_CTRL_ST_EN_BIT] && (st_cnt == st_period);
  assign wake_any = gpio_rise | t0_fire | st_fire | i2c_rise |
    (analog_rise & sleep_ctrl[`SWC_CTRL_ANALOG_EN_BIT]);

  // Event collection with the documented loss windows
  always @*
  begin
    events = {`SWC_NUM_INT{1'b0}};
    events[`SWC_INT_GPIO] = gpio_rise;
    events[`SWC_INT_TIMER0] = t0_fire;
    events[`SWC_INT_SLEEPT] = st_fire;
    events[`SWC_INT_ANALOG] = analog_rise & sleep_ctrl[`SWC_CTRL_ANALOG_EN_BIT];
    events[`SWC_INT_I2C] = i2c_rise;
    events[`SWC_INT_LOCKUP] = (state == ST_SLEEP) && wake_any && long_refresh;
    // Timer wake in sleep swallows a coincident GPIO event
    if ((state == ST_SLEEP) && (t0_fire || st_fire))
      events[`SWC_INT_GPIO] = 1'b0; // R09
  end

  // Events posted in the cycles just ahead of a sleep command
  always @*
  begin
    recent_events = {`SWC_NUM_INT{1'b0}};
    for (k = 0; k < `SWC_DROP_CYCLES; k = k + 1)
      recent_events = recent_events | event_hist[k*`SWC_NUM_INT +: `SWC_NUM_INT];
  end

  // Set wins over write-one-to-clear
  always @*
  begin
    next_status = int_status;
    if (reg_wr && (reg_addr == `SWC_OFS_INT_STATUS))
      next_status = int_status & ~reg_wdata[`SWC_NUM_INT-1:0];
    if (sleep_cmd)
      next_status = next_status & ~recent_events; // R11
    next_status = next_status | (sleep_cmd ? {`SWC_NUM_INT{1'b0}} : events);
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (sleep_cmd)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake_any)
          next_state = long_refresh ? ST_LOCK : ST_WAKE; // R03
      ST_LOCK:
        next_state = ST_LOCK; // R03
      ST_WAKE:
        next_state = sleep_cmd ? ST_SLEEP : ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_RUN;
      pins_prev <= 3'h0;
      timer0_cfg <= `SWC_RESET_BYTE;
      sleep_cfg2 <= `SWC_RESET_BYTE;
      oscillator_control_zero_reg <= `SWC_RESET_BYTE;
      sleep_ctrl <= `SWC_RESET_BYTE;
      t0_period <= `SWC_RESET_BYTE;
      st_period <= `SWC_RESET_BYTE;
      int_status <= {`SWC_NUM_INT{1'b0}};
      int_mask <= {`SWC_NUM_INT{1'b0}};
      refresh_cnt <= {(`SWC_CNT_W+4){1'b0}};
      t0_cnt <= 8'h00;
      st_cnt <= 8'h00;
      event_hist <= {(`SWC_DROP_CYCLES*`SWC_NUM_INT){1'b0}};
      reg_rdata <= 8'h00;
      bandgap_power_en <= 1'b1;
      sleeping <= 1'b0;
      locked_up <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pins_prev <= pins_sync;
      int_status <= next_status;
      // Short event history, so a sleep command can swallow late events
      event_hist <= {event_hist[(`SWC_DROP_CYCLES-1)*`SWC_NUM_INT-1:0], events};
      if (reg_wr)
      begin
        case (reg_addr)
          `SWC_OFS_TIMER0_CFG: timer0_cfg <= reg_wdata;
          `SWC_OFS_SLEEP_CFG2: sleep_cfg2 <= reg_wdata;
          `SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG: oscillator_control_zero_reg <= reg_wdata;
          `SWC_OFS_SLEEP_CTRL: sleep_ctrl <= reg_wdata & ~(8'h01 << `SWC_CTRL_SLEEP_BIT);
          `SWC_OFS_INT_MASK: int_mask <= reg_wdata[`SWC_NUM_INT-1:0];
          `SWC_OFS_T0_PERIOD: t0_period <= reg_wdata;
          `SWC_OFS_ST_PERIOD: st_period <= reg_wdata;
          default: ;
        endcase
      end
      // A write elsewhere must not keep a one-shot timer running
      if (t0_fire && timer0_cfg[`SWC_T0_ONESHOT_BIT] && !(reg_wr && (reg_addr == `SWC_OFS_TIMER0_CFG)))
        timer0_cfg[`SWC_T0_ENABLE_BIT] <= 1'b0; // R07
      // Timer 0: periodic, or stops after one expiry in one-shot mode
      if (t0_fire || !timer0_cfg[`SWC_T0_ENABLE_BIT])
        t0_cnt <= 8'h00;
      else
        t0_cnt <= t0_cnt + 8'h01;
      if (st_fire || !sleep_ctrl[`SWC_CTRL_ST_EN_BIT])
        st_cnt <= 8'h00;
      else
        st_cnt <= st_cnt + 8'h01;
      // Bandgap refresh pulses only while asleep
      if (state != ST_SLEEP || refresh_disable) // R02
      begin
        refresh_cnt <= {(`SWC_CNT_W+4){1'b0}};
        bandgap_power_en <= (state != ST_SLEEP);
      end
      else if (refresh_cnt >= refresh_limit - 1'b1)
      begin
        refresh_cnt <= {(`SWC_CNT_W+4){1'b0}};
        bandgap_power_en <= 1'b1; // R01
      end
      else
      begin
        refresh_cnt <= refresh_cnt + 1'b1;
        bandgap_power_en <= 1'b0;
      end
      sleeping <= (next_state == ST_SLEEP) || (next_state == ST_LOCK);
      locked_up <= (next_state == ST_LOCK);
      irq <= |(next_status & int_mask);
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `SWC_OFS_TIMER0_CFG: reg_rdata <= timer0_cfg;
          `SWC_OFS_SLEEP_CFG2: reg_rdata <= sleep_cfg2;
          `SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG: reg_rdata <= oscillator_control_zero_reg;
          `SWC_OFS_SLEEP_CTRL: reg_rdata <= sleep_ctrl;
          `SWC_OFS_INT_STATUS: reg_rdata <= {2'b00, int_status};
          `SWC_OFS_INT_MASK: reg_rdata <= {2'b00, int_mask};
          `SWC_OFS_STATE: reg_rdata <= {6'h00, state};
          `SWC_OFS_T0_PERIOD: reg_rdata <= t0_period;
          `SWC_OFS_ST_PERIOD: reg_rdata <= st_period;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/swc_chk.sv
// Port assertions for the sleep and wake controller.
// Assumes the register map of swc_defs.vh; bound to swc_top.
`include "swc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module swc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic gpio_wake_pin,
  input wire logic analog_event_pin,
  input wire logic i2c_wake_pin,
  input wire logic bandgap_power_en,
  input wire logic sleeping,
  input wire logic locked_up,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_sleep_cmd;
    reg_wr && reg_addr == `SWC_OFS_SLEEP_CTRL && reg_wdata[`SWC_CTRL_SLEEP_BIT] && !sleeping;
  endsequence
  sequence s_state_rd;
    reg_rd && reg_addr == `SWC_OFS_STATE && locked_up;
  endsequence
  a_sleep_enter: assert property (s_sleep_cmd |=> sleeping) else $error("sleep not entered");
  a_pulse_short: assert property (sleeping && !locked_up && bandgap_power_en |=> !bandgap_power_en)
    else $error("refresh pulse too long");
  a_lock_holds: assert property (locked_up |=> locked_up && sleeping) else $error("lock left");
  a_lock_source: assert property ($rose(locked_up) |-> $past(sleeping)) else $error("lock from run");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  a_state_lock: assert property (s_state_rd |=> reg_rdata == 8'h02) else $error("state not lock");
endmodule
bind swc_top swc_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_wake_pin(gpio_wake_pin),
  .analog_event_pin(analog_event_pin), .i2c_wake_pin(i2c_wake_pin), .bandgap_power_en(bandgap_power_en),
  .sleeping(sleeping), .locked_up(locked_up), .irq(irq));
`default_nettype wire

// ### verification/swc_host.sv
// Pin-side partner: host GPIO line, analog source and external I2C master.
// Assumes pins change just after a clk_sys rising edge.
`timescale 1ns/1ps
`default_nettype none
module swc_host (
  input wire logic clk_sys,
  input wire logic sleeping,
  output logic gpio_wake_pin,
  output logic analog_event_pin,
  output logic i2c_wake_pin
);
  logic [2:0] lvl = 3'h0;
  assign gpio_wake_pin = lvl[0];
  assign analog_event_pin = lvl[1];
  assign i2c_wake_pin = lvl[2];
  // Held 4 cycles so the synchroniser cannot miss it
  // Static, so the bit index may stand in a non-blocking assignment
  task pulse(input int pin);
    @(posedge clk_sys);
    lvl[pin] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    lvl[pin] <= 1'b0;
  endtask
  // Master holds its transfer at most 20 cycles while waiting for the device to wake
  task automatic i2c_wake(output bit woke);
    pulse(2);
    for (int n = 0; n < 20 && sleeping !== 1'b0; n++) @(posedge clk_sys);
    woke = (sleeping === 1'b0);
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for swc_top with the pin-side partner.
// Assumes a 125 MHz clk_sys and the register map of swc_defs.vh.
`include "swc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic gp, an, ic, bg, slp, lck, irq;
  int failures = 0;
  int total_checks = 0;
  int n;
  bit woke;
  logic [31:0] seed = 32'hAC70E6DF;
  always #4 clk_sys = ~clk_sys;
  swc_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_wake_pin(gp), .analog_event_pin(an), .i2c_wake_pin(ic),
    .bandgap_power_en(bg), .sleeping(slp), .locked_up(lck), .irq(irq));
  swc_host host (.clk_sys(clk_sys), .sleeping(slp), .gpio_wake_pin(gp), .analog_event_pin(an), .i2c_wake_pin(ic));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(what, exp, reg_rdata);
  endtask
  // Outputs packed as locked, sleeping, bandgap, irq; sampled after settling
  task automatic pin_chk(input string what, input logic [3:0] exp);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(what, {4'h0, exp}, {4'h0, lck, slp, bg, irq});
  endtask
  task automatic conclude();
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #480000;
    failures++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    check("bandgap in reset", 8'h01, {7'h00, bg});
    rst_n <= 1'b1;
    rd(`SWC_OFS_TIMER0_CFG, `SWC_RESET_BYTE, "timer0 cfg reset");
    rd(8'hC0, 8'h00, "unmapped");
    seed = lfsr(seed);
    wr(`SWC_OFS_T0_PERIOD, seed[7:0]);
    rd(`SWC_OFS_T0_PERIOD, seed[7:0], "timer0 period");
    wr(`SWC_OFS_T0_PERIOD, {3'h0, seed[12:8]} + 8'h08);
    wr(`SWC_OFS_TIMER0_CFG, 8'h03);
    repeat (60) @(posedge clk_sys);
    rd(`SWC_OFS_INT_STATUS, 8'h02, "status timer0");
    rd(`SWC_OFS_TIMER0_CFG, 8'h02, "timer0 cfg after expiry");
    wr(`SWC_OFS_TIMER0_CFG, 8'h02 & 8'hFD);
    pin_chk("outputs masked", 4'h2);
    wr(`SWC_OFS_INT_MASK, 8'h3F);
    pin_chk("outputs unmasked", 4'h3);
    wr(`SWC_OFS_INT_STATUS, 8'h02);
    pin_chk("outputs cleared", 4'h2);
    wr(`SWC_OFS_SLEEP_CFG2, `SWC_RESET_BYTE);
    wr(`SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG, `SWC_RESET_BYTE);
    // Timers stay off, analog enable stays clear, I2C quiet until awake
    for (n = 0; n < 2; n++)
    begin
      wr(`SWC_OFS_SLEEP_CTRL, 8'h01);
      pin_chk("outputs asleep", 4'h4);
      if (n == 0)
      begin
        host.pulse(1);
        pin_chk("outputs analog off", 4'h4);
        host.pulse(0);
      end
      else
        host.i2c_wake(woke);
      pin_chk("outputs woken", 4'h3);
      rd(`SWC_OFS_INT_STATUS, (n == 0) ? 8'h01 : 8'h10, "status wake source");
      wr(`SWC_OFS_INT_STATUS, 8'h3F);
    end
    check("i2c master woke", 8'h01, {7'h00, woke});
    // GPIO edge one cycle ahead of the sleep command
    fork
      host.pulse(0);
      begin
        repeat (3) @(posedge clk_sys);
        wr(`SWC_OFS_SLEEP_CTRL, 8'h01);
      end
    join
    host.i2c_wake(woke);
    rd(`SWC_OFS_INT_STATUS, 8'h10, "status gpio dropped");
    wr(`SWC_OFS_INT_STATUS, 8'h3F);
    wr(`SWC_OFS_SLEEP_CFG2, 8'h01);
    wr(`SWC_OFS_SLEEP_CTRL, 8'h01);
    host.pulse(0);
    pin_chk("outputs locked", 4'hF);
    rd(`SWC_OFS_STATE, 8'h02, "state locked");
    rd(`SWC_OFS_INT_STATUS, 8'h21, "status lockup");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    pin_chk("outputs after reset", 4'h2);
    rd(`SWC_OFS_SLEEP_CFG2, `SWC_RESET_BYTE, "refresh field reset");
    wr(`SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG, 8'h01);
    rd(`SWC_OFS_OSCILLATOR_CONTROL_ZERO_REG, 8'h01, "refresh disable");
    wr(`SWC_OFS_SLEEP_CTRL, 8'h01);
    pin_chk("outputs refresh off", 4'h4);
    host.i2c_wake(woke);
    pin_chk("outputs locked no refresh", 4'hE);
    conclude();
  end
endmodule
`default_nettype wire
